/* File: shared/rscl_defines.vh */
`ifndef RSCL_DEFINES_VH
`define RSCL_DEFINES_VH

// Register byte offsets
`define RSCL_ADDR_CTRL      4'h0
`define RSCL_ADDR_STATUS    4'h4
`define RSCL_ADDR_FIXMASK   4'h8

// Control register fields
`define RSCL_CTRL_FIXED_EN  0
`define RSCL_CTRL_LED_EN    1
`define RSCL_CTRL_RESET     2'h3

// Status register fields
`define RSCL_ST_CFG_LSB     0
`define RSCL_ST_FIXED_LSB   4
`define RSCL_ST_VALID       8
`define RSCL_ST_SHORT       9
`define RSCL_ST_IN_RESET    10

// Fixed-port codes
`define RSCL_FIXED_NONE     2'h0
`define RSCL_FIXED_P1       2'h1
`define RSCL_FIXED_P12      2'h2
`define RSCL_FIXED_P123     2'h3

// AXI responses
`define RSCL_RESP_OKAY      2'h0
`define RSCL_RESP_SLVERR    2'h2

// Least low time of the external reset, and clock period
`define RSCL_RST_MIN_NS     1000
`define RSCL_CLK_NS         10
`define RSCL_RST_MIN_CYC    ((`RSCL_RST_MIN_NS + `RSCL_CLK_NS - 1) / `RSCL_CLK_NS)

`endif

/* File: logic/rscl_sync.v */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser, one per bit; the first stage feeds only the second
module rscl_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input  wire             aclk,
    input  wire             aresetn,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1;
            reg stage2;
            // Metastability guard for asynchronous pin levels
            always @(posedge aclk) begin
                if (!aresetn) begin
                    stage1 <= RESET_VALUE[i];
                    stage2 <= RESET_VALUE[i];
                end else begin
                    stage1 <= din[i];
                    stage2 <= stage1;
                end
            end
            assign dout[i] = stage2;
        end
    endgenerate
endmodule // rscl_sync

`default_nettype wire

/* File: logic/rscl_top.v */
// What this block does
// - Sample upper fixed-port strap bit when external reset is released
// - Use fixed-port straps only if package and settings enable them
// - Code 00 means all ports removable; 01 means port 1 fixed
// - Code 10 fixes ports 1,2; code 11 fixes 1,2,3 when present
// - Latch config select bit 0 at external reset release
// - Latch config select bit 1 at external reset release
// - Latch config select bit 2; treat as 0 if pin absent
// - Speed LED active high if select bit 1 is 0, else low
// - Assert speed LED at high-speed upstream link, negate at full speed
// - Sample lower fixed-port strap bit together with the upper one
//
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "rscl_defines.vh"

module rscl_top #(
    parameter NPORTS           = 7,
    parameter PKG_HAS_FIXED    = 1,
    parameter PKG_HAS_CFG_SEL2 = 1
) (
    input  wire              aclk,
    input  wire              aresetn,
    // External reset pin and strap pins
    input  wire              ext_reset_n,
    input  wire [1:0]        fixed_port_strap,
    input  wire [2:0]        cfg_sel,
    // Upstream link state from the hub core, same clock
    input  wire              link_connected,
    input  wire              link_highspeed,
    // Speed LED pin, shared with config select bit 1
    input  wire              highspeed_link_led_i,
    output reg               highspeed_link_led_o,
    output reg               highspeed_link_led_oe,
    // Latched results
    output reg  [2:0]        cfg_method,
    output reg  [NPORTS-1:0] fixed_port_mask,
    output reg               straps_valid,
    // AXI4-Lite slave
    input  wire [3:0]        s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [3:0]        s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready
);
    // Minimum low time in clocks; cut to the width of the low-time counter
    localparam integer RST_MIN_INT = `RSCL_RST_MIN_CYC;
    localparam [7:0]   RST_MIN_CYC = RST_MIN_INT[7:0];

    wire        rst_pin_s;
    wire [1:0]  fixed_s;
    wire [2:0]  cfg_s;
    reg         rst_pin_q;
    reg  [7:0]  low_cnt;
    reg  [1:0]  fixed_code;
    reg         short_pulse;
    reg  [1:0]  ctrl;
    reg  [3:0]  aw_addr;
    reg         aw_have;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_have;
    reg  [31:0] next_rdata;
    reg  [1:0]  next_rresp;
    wire [NPORTS-1:0] next_mask;
    wire        release_edge;
    wire        led_active;

    // Pins are asynchronous; reset pin idles in its asserted state
    rscl_sync #(.WIDTH(6), .RESET_VALUE(6'h00)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({ext_reset_n, fixed_port_strap, cfg_sel[2], highspeed_link_led_i,
                   cfg_sel[0]}),
        .dout    ({rst_pin_s, fixed_s, cfg_s[2], cfg_s[1], cfg_s[0]})
    );

    // Straps and reset pass the same two stages, so they stay aligned
    assign release_edge = rst_pin_s & ~rst_pin_q;

    // Decode the fixed-port code into a per-port mask
    genvar p;
    generate
        for (p = 0; p < NPORTS; p = p + 1) begin : g_port
            // One driver per bit; code 00 leaves every port removable
            assign next_mask[p] = (fixed_s == `RSCL_FIXED_P1)   ? (p == 0) :
                                  (fixed_s == `RSCL_FIXED_P12)  ? (p <= 1) :
                                  (fixed_s == `RSCL_FIXED_P123) ? (p <= 2) :
                                  1'b0;
        end
    endgenerate

    // Measure the low time of the external reset, saturating at the minimum
    always @(posedge aclk) begin
        if (!aresetn) begin
            rst_pin_q <= 1'b0;
            low_cnt   <= 8'h00;
        end else begin
            rst_pin_q <= rst_pin_s;
            if (rst_pin_s) begin
                low_cnt <= 8'h00;
            end else if (low_cnt < RST_MIN_CYC) begin
                low_cnt <= low_cnt + 8'h01;
            end
        end
    end

    // Capture straps once at release; later pin use cannot disturb them
    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg_method      <= 3'h0;
            fixed_code      <= 2'h0;
            fixed_port_mask <= {NPORTS{1'b0}};
            straps_valid    <= 1'b0;
            short_pulse     <= 1'b0;
        end else if (!rst_pin_s) begin
            straps_valid <= 1'b0;
        end else if (release_edge) begin
            cfg_method[0] <= cfg_s[0];
            cfg_method[1] <= cfg_s[1];
            cfg_method[2] <= (PKG_HAS_CFG_SEL2 != 0) ? cfg_s[2] : 1'b0;
            straps_valid  <= 1'b1;
            short_pulse   <= (low_cnt < RST_MIN_CYC);
            if ((PKG_HAS_FIXED != 0) && ctrl[`RSCL_CTRL_FIXED_EN]) begin
                fixed_code      <= fixed_s;
                fixed_port_mask <= next_mask;
            end else begin
                fixed_code      <= `RSCL_FIXED_NONE;
                fixed_port_mask <= {NPORTS{1'b0}};
            end
        end
    end

    // Speed LED: pin is a strap input during reset, then an output
    assign led_active = link_connected & link_highspeed;
    always @(posedge aclk) begin
        if (!aresetn) begin
            highspeed_link_led_oe <= 1'b0;
            highspeed_link_led_o  <= 1'b0;
        end else begin
            highspeed_link_led_oe <= straps_valid & ctrl[`RSCL_CTRL_LED_EN];
            // Polarity comes from the latched select bit, not the live pin
            highspeed_link_led_o  <= led_active ^ cfg_method[1];
        end
    end

    // Write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RSCL_RESP_OKAY;
            aw_have       <= 1'b0;
            w_have        <= 1'b0;
            aw_addr       <= 4'h0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            ctrl          <= `RSCL_CTRL_RESET;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_have && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                aw_have       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                w_have       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
            end
            if (aw_have && w_have && !s_axi_bvalid) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr == `RSCL_ADDR_CTRL) begin
                    s_axi_bresp <= `RSCL_RESP_OKAY;
                    if (w_strb[0]) begin
                        ctrl <= w_data[1:0];
                    end
                end else if (aw_addr == `RSCL_ADDR_STATUS ||
                             aw_addr == `RSCL_ADDR_FIXMASK) begin
                    s_axi_bresp <= `RSCL_RESP_OKAY;                // Read-only, write ignored
                end else begin
                    s_axi_bresp <= `RSCL_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read data mux; unmapped offsets answer SLVERR with zero data
    always @* begin
        next_rdata = 32'h00000000;
        next_rresp = `RSCL_RESP_OKAY;
        case (s_axi_araddr)
            `RSCL_ADDR_CTRL: begin
                next_rdata[1:0] = ctrl;
            end
            `RSCL_ADDR_STATUS: begin
                next_rdata[`RSCL_ST_CFG_LSB +: 3]   = cfg_method;
                next_rdata[`RSCL_ST_FIXED_LSB +: 2] = fixed_code;
                next_rdata[`RSCL_ST_VALID]          = straps_valid;
                next_rdata[`RSCL_ST_SHORT]          = short_pulse;
                next_rdata[`RSCL_ST_IN_RESET]       = ~rst_pin_s;
            end
            `RSCL_ADDR_FIXMASK: begin
                next_rdata[NPORTS-1:0] = fixed_port_mask;
            end
            default: begin
                next_rresp = `RSCL_RESP_SLVERR;
            end
        endcase
    end

    // Read channel: one read in flight
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RSCL_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= next_rdata;
                s_axi_rresp   <= next_rresp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // rscl_top

`default_nettype wire

/* File: tb/rscl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// Watches strap capture and speed LED at the top module's ports
module rscl_checker #(
    parameter NPORTS           = 7,
    parameter PKG_HAS_CFG_SEL2 = 1
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              ext_reset_n,
    input wire logic [1:0]        fixed_port_strap,
    input wire logic [2:0]        cfg_sel,
    input wire logic              link_connected,
    input wire logic              link_highspeed,
    input wire logic              highspeed_link_led_i,
    input wire logic              highspeed_link_led_o,
    input wire logic              highspeed_link_led_oe,
    input wire logic [2:0]        cfg_method,
    input wire logic [NPORTS-1:0] fixed_port_mask,
    input wire logic              straps_valid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Capture lands three edges after the pin rises: two sync stages plus one
    AST_CAPTURE: assert property ($rose(ext_reset_n) ##1 ext_reset_n[*3] |-> straps_valid)
        else $error("straps not valid three edges after reset release");
    // Valid drops one edge after the synced fall, the led enable one edge later
    AST_CLEAR: assert property (!ext_reset_n[*5] |-> !straps_valid && !highspeed_link_led_oe)
        else $error("valid or led drive kept during external reset");
    AST_CFG0: assert property ($rose(straps_valid) |-> cfg_method[0] == $past(cfg_sel[0], 3))
        else $error("select bit 0 not the pin level at release");
    AST_CFG1: assert property ($rose(straps_valid) |-> cfg_method[1] == $past(highspeed_link_led_i, 3))
        else $error("select bit 1 not the led pin level at release");
    AST_CFG2: assert property ($rose(straps_valid) |-> cfg_method[2] ==
        ((PKG_HAS_CFG_SEL2 != 0) ? $past(cfg_sel[2], 3) : 1'b0))
        else $error("select bit 2 not the pin level at release");
    // A disabled strap gives an empty mask, so only a non-empty one is decoded
    AST_FIXED: assert property ($rose(straps_valid) && fixed_port_mask != 0 |->
        fixed_port_mask == NPORTS'((1 << $past(fixed_port_strap, 3)) - 1))
        else $error("fixed port mask does not match sampled strap");
    AST_MASK: assert property (straps_valid |-> fixed_port_mask inside {0, 1, 3, 7})
        else $error("fixed port mask is not a legal code");
    AST_HOLD: assert property (straps_valid && $past(straps_valid) |->
        $stable(cfg_method) && $stable(fixed_port_mask))
        else $error("latched straps changed while valid");
    AST_LED: assert property (straps_valid && $past(straps_valid) |-> highspeed_link_led_o ==
        ($past(link_connected && link_highspeed) ^ cfg_method[1]))
        else $error("speed led level wrong");
endmodule // rscl_checker

bind rscl_top rscl_checker #(.NPORTS(NPORTS), .PKG_HAS_CFG_SEL2(PKG_HAS_CFG_SEL2))
    rscl_checker_inst (.aclk, .aresetn, .ext_reset_n,
    .fixed_port_strap, .cfg_sel, .link_connected, .link_highspeed, .highspeed_link_led_i,
    .highspeed_link_led_o, .highspeed_link_led_oe, .cfg_method, .fixed_port_mask, .straps_valid);
`default_nettype wire

/* File: tb/rscl_board.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rscl_defines.vh"
// Board side: reset driver and strap levels on the pins
module rscl_board (
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [4:0] strap,
    input  wire logic       led_o,
    input  wire logic       led_oe,
    output logic            ext_reset_n,
    output logic [1:0]      fixed_port_strap,
    output logic [2:0]      cfg_sel,
    output logic            led_pin
);
    int   cnt = 0;
    logic drive;
    // Low from power-up; go restarts a pulse never shorter than the minimum
    initial ext_reset_n = 1'b0;
    always @(posedge aclk) begin
        cnt <= cnt + 1;
        if (go) begin
            ext_reset_n <= 1'b0;
            cnt <= 0;
        end else if (!ext_reset_n && cnt >= `RSCL_RST_MIN_CYC) begin
            ext_reset_n <= 1'b1;
            cnt <= 0;
        end
    end
    // Straps flip 8 cycles past release, so a late sample shows up
    assign drive = !ext_reset_n || cnt < 8;
    assign {cfg_sel, fixed_port_strap} = drive ? strap : ~strap;
    assign led_pin = led_oe ? led_o : cfg_sel[1]; // Hub drive wins over strap
endmodule // rscl_board
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rscl_defines.vh"
module testbench;
    logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, conn = 1'b0, hs = 1'b0;
    logic [4:0]  strap = 5'h00;
    logic        ext_n, led_i, led_o, led_oe, valid, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  fix, bresp, rresp, r;
    logic [2:0]  cfg, cfg_m;
    logic [6:0]  mask;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, d, st;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    int          n_errors = 0, samples_checked = 0;

    always #5 aclk = ~aclk;

    rscl_top rscl_top_inst (.aclk, .aresetn, .ext_reset_n(ext_n), .fixed_port_strap(fix),
        .cfg_sel(cfg), .link_connected(conn), .link_highspeed(hs),
        .highspeed_link_led_i(led_i), .highspeed_link_led_o(led_o),
        .highspeed_link_led_oe(led_oe), .cfg_method(cfg_m), .fixed_port_mask(mask),
        .straps_valid(valid), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    rscl_board rscl_board_inst (.aclk, .go, .strap, .led_o, .led_oe, .ext_reset_n(ext_n),
        .fixed_port_strap(fix), .cfg_sel(cfg), .led_pin(led_i));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Each channel is released at its own handshake; ready waits for the answer
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        r = bresp;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    // Two edges let the pin fall before waiting for the fresh capture
    task automatic pulse;
        while (!ext_n) @(posedge aclk);
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (2) @(posedge aclk);
        while (!(ext_n && valid)) @(posedge aclk);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog well beyond eight reset pulses
    initial begin
        #100000;
        n_errors++;
        stop_test();
    end

    // Register map first, then one capture per strap pattern and enable setting
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`RSCL_ADDR_CTRL);
        check("ctrl reset", d, 32'h3);
        rd(4'hC);
        check("unmapped read", r, `RSCL_RESP_SLVERR);
        wr(4'hC, 32'h0);
        check("unmapped write", r, `RSCL_RESP_SLVERR);
        wr(`RSCL_ADDR_STATUS, 32'hFFFFFFFF);
        check("status write", r, `RSCL_RESP_OKAY);
        wstrb <= 4'h0;
        wr(`RSCL_ADDR_CTRL, 32'h0);
        wstrb <= 4'hF;
        rd(`RSCL_ADDR_CTRL);
        check("ctrl masked write", d, 32'h3);
        $display("test map done");
        for (int i = 0; i < 8; i++) begin
            strap <= {i[0], i[1], ~i[2], i[1:0]};
            wr(`RSCL_ADDR_CTRL, i < 4 ? 32'h3 : (i < 6 ? 32'h2 : 32'h0));
            pulse();
            // Valid at bit 8, in-reset clear, short (bit 9) masked off, fixed code at 5:4, select at 2:0
            st = {21'h0, 3'b001, 2'b00, (i < 4 ? i[1:0] : 2'h0), 1'b0, i[0], i[1], ~i[2]};
            rd(`RSCL_ADDR_STATUS);
            check("status", d & 32'h5FF, st);
            rd(`RSCL_ADDR_FIXMASK);
            check("fixed mask", d, i < 4 ? (32'h1 << i[1:0]) - 1 : 32'h0);
            check("led enable", led_oe, i < 6);
            for (int j = 0; j < 3 && i < 6; j++) begin
                conn <= j != 2;
                hs <= j != 1;
                repeat (3) @(posedge aclk);
                check("led level", led_o, (j == 0) ^ i[1]);
            end
            rd(`RSCL_ADDR_STATUS);
            check("status held", d & 32'h5FF, st);
            $display("test capture %0d done", i);
        end
        stop_test();
    end
endmodule // testbench
`default_nettype wire
